//--- acr_cfg.svh
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

// Register indices as printed; byte address is four times the index
`define ACR_IDX_RES_LOW      8'h78
`define ACR_IDX_RES_HIGH     8'h79
`define ACR_IDX_MAIN_CTRL    8'h7A
`define ACR_IDX_TRIG_CTRL    8'h7B
`define ACR_IDX_CHAN_SEL     8'h7C
`define ACR_IDX_PIN_DIS      8'h7E

// Main control field positions
`define ACR_MC_ENABLE        7
`define ACR_MC_START         6
`define ACR_MC_AUTO          5
`define ACR_MC_DONE          4
`define ACR_MC_IRQ_EN        3

// Channel select field positions
`define ACR_CS_LEFT          5

// Writable masks
`define ACR_TRIG_MASK        8'h47
`define ACR_CHAN_MASK        8'hEF
`define ACR_PIN_MASK         8'h3F

// Reset values
`define ACR_RESET_BYTE       8'h00

// Conversion lengths in converter clock cycles
`define ACR_FIRST_CYCLES     6'd25
`define ACR_NORMAL_CYCLES    6'd13

`endif

//--- acr_pkg.sv
package acr_pkg;

   typedef enum logic [1:0]
   {
      ACR_IDLE,
      ACR_BUSY
   } acr_conv_e;

   typedef struct packed
   {
      logic [9:0] result;
      logic       done;
   } acr_core_s;

   typedef struct packed
   {
      logic [3:0] channel;
      logic [1:0] reference;
   } acr_sel_s;

endpackage : acr_pkg

//--- acr_prescaler.sv
`include "acr_cfg.svh"

module acr_prescaler
   import acr_pkg::*;
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       clk_en,
   // Control
   input  wire logic       run,
   input  wire logic [2:0] div_sel,
   // Converter clock tick, one system cycle wide
   output logic            conv_tick
);

   logic [6:0] cnt_q;
   logic [6:0] cnt_d;
   logic       tick_d;
   logic [6:0] last;

   // Codes 0 and 1 both divide by two
   always_comb
   begin
      case (div_sel)
         3'h0, 3'h1: last = 7'h01;
         3'h2:       last = 7'h03;
         3'h3:       last = 7'h07;
         3'h4:       last = 7'h0F;
         3'h5:       last = 7'h1F;
         3'h6:       last = 7'h3F;
         default:    last = 7'h7F;
      endcase
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      if (!run)
         cnt_d = 7'h00;
      else if (cnt_q >= last)
      begin
         cnt_d  = 7'h00;
         tick_d = 1'b1;
      end
      else
         cnt_d = cnt_q + 7'h01;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q     <= 7'h00;
         conv_tick <= 1'b0;
      end
      else if (clk_en)
      begin
         cnt_q     <= cnt_d;
         conv_tick <= tick_d;
      end
   end

endmodule : acr_prescaler

//--- acr_ctrl.sv
// Chosen here: register access over APB.
`include "acr_cfg.svh"

module acr_ctrl
   import acr_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Processor side
   input  wire logic        global_irq_en,
   input  wire logic        irq_ack,
   output logic             conv_irq,
   // Trigger sources, index 1..7; index 0 is the done flag
   input  wire logic [7:1]  trig_src,
   // Analog core
   input  wire logic [9:0]  core_result,
   output logic             core_busy,
   output logic             core_sample,
   output logic [5:0]       core_sel,
   // Digital pins
   input  wire logic [5:0]  pin_in,
   output logic [5:0]       pin_buf_off,
   output logic [5:0]       pin_read
);

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic [7:0]  main_q, main_d;
   logic [7:0]  trig_q, trig_d;
   logic [7:0]  chan_q, chan_d;
   logic [7:0]  pin_q, pin_d;
   logic [9:0]  res_q, res_d;
   logic        lock_q, lock_d;
   acr_sel_s    act_q, act_d;
   acr_conv_e   st_q, st_d;
   logic [5:0]  cyc_q, cyc_d;
   logic        first_q, first_d;
   logic        trig_lvl_q, trig_lvl_d;
   logic        pready_d;
   logic [31:0] prdata_d;
   logic        pslverr_d;
   logic        irq_d;
   logic        sample_d;

   logic        wr_en, rd_en;
   logic [9:0]  idx;
   logic        conv_tick;
   logic        done_evt;
   logic        trig_now;
   logic [7:0]  lo_view, hi_view;
   logic [7:0]  src_vec;

   assign wr_en = psel && penable && pwrite && !pready;
   assign rd_en = psel && penable && !pwrite && !pready;
   assign idx   = paddr[11:2];

   acr_prescaler u_presc
   (
      .pclk      (pclk),
      .presetn   (presetn),
      .clk_en    (clk_en),
      .run       (st_q == ACR_BUSY),
      .div_sel   (main_q[2:0]),
      .conv_tick (conv_tick)
   );

   // ------------------------------------------------------------
   // Result presentation
   // ------------------------------------------------------------
   always_comb
   begin
      if (chan_q[`ACR_CS_LEFT])
      begin
         hi_view = res_q[9:2];
         lo_view = {res_q[1:0], 6'h00};
      end
      else
      begin
         hi_view = {6'h00, res_q[9:8]};
         lo_view = res_q[7:0];
      end
   end

   // Done flag feeds trigger code zero (free running)
   assign src_vec = {trig_src, main_q[`ACR_MC_DONE]};

   // ------------------------------------------------------------
   // Trigger and conversion sequencing
   // ------------------------------------------------------------
   always_comb
   begin
      trig_lvl_d = src_vec[trig_q[2:0]];
      // Edge is judged before the forcing, so the write cannot trigger
      trig_now = main_q[`ACR_MC_AUTO]
                 && trig_lvl_d && !trig_lvl_q;
      // Free running selection never produces a switch edge
      if (wr_en && idx == 10'(`ACR_IDX_TRIG_CTRL)
          && pwdata[2:0] == 3'h0 && trig_q[2:0] != 3'h0)
         trig_lvl_d = 1'b1;
   end

   always_comb
   begin
      st_d     = st_q;
      cyc_d    = cyc_q;
      first_d  = first_q;
      act_d    = act_q;
      done_evt = 1'b0;
      sample_d = 1'b0;
      case (st_q)
         ACR_IDLE:
         begin
            if (main_q[`ACR_MC_ENABLE] &&
                (main_q[`ACR_MC_START] || trig_now))
            begin
               st_d     = ACR_BUSY;
               cyc_d    = 6'h00;
               act_d    = '{channel: chan_q[3:0],
                            reference: chan_q[7:6]};
            end
         end
         ACR_BUSY:
         begin
            if (!main_q[`ACR_MC_ENABLE])
            begin
               st_d    = ACR_IDLE;
               first_d = 1'b1;
            end
            else if (conv_tick)
            begin
               cyc_d = cyc_q + 6'h01;
               if (cyc_q + 6'h01 == (first_q ? `ACR_FIRST_CYCLES
                                             : `ACR_NORMAL_CYCLES))
               begin
                  st_d     = ACR_IDLE;
                  first_d  = 1'b0;
                  done_evt = 1'b1;
                  sample_d = 1'b1;
               end
            end
         end
         default:
            st_d = ACR_IDLE;
      endcase
      if (!main_q[`ACR_MC_ENABLE])
         first_d = 1'b1;
   end

   // ------------------------------------------------------------
   // Register writes, flag and result handling
   // ------------------------------------------------------------
   always_comb
   begin
      main_d = main_q;
      trig_d = trig_q;
      chan_d = chan_q;
      pin_d  = pin_q;
      res_d  = res_q;
      lock_d = lock_q;
      if (wr_en)
      begin
         case (idx)
            10'(`ACR_IDX_MAIN_CTRL):
            begin
               main_d[7] = pwdata[7];
               main_d[5] = pwdata[5];
               main_d[3:0] = {pwdata[3], pwdata[2:0]};
               if (pwdata[`ACR_MC_START])
                  main_d[`ACR_MC_START] = 1'b1;
               if (pwdata[`ACR_MC_DONE])
                  main_d[`ACR_MC_DONE] = 1'b0;
            end
            10'(`ACR_IDX_TRIG_CTRL):
               trig_d = pwdata[7:0] & `ACR_TRIG_MASK;
            10'(`ACR_IDX_CHAN_SEL):
               chan_d = pwdata[7:0] & `ACR_CHAN_MASK;
            10'(`ACR_IDX_PIN_DIS):
               pin_d = pwdata[7:0] & `ACR_PIN_MASK;
            default:
               main_d = main_d;
         endcase
      end
      if (irq_ack)
         main_d[`ACR_MC_DONE] = 1'b0;
      if (rd_en && idx == 10'(`ACR_IDX_RES_LOW))
         lock_d = 1'b1;
      if (rd_en && idx == 10'(`ACR_IDX_RES_HIGH))
         lock_d = 1'b0;
      if (st_q == ACR_IDLE && st_d == ACR_BUSY)
         main_d[`ACR_MC_START] = 1'b1;
      if (st_q == ACR_BUSY && st_d == ACR_IDLE)
         main_d[`ACR_MC_START] = 1'b0;
      if (!main_d[`ACR_MC_ENABLE] && st_q == ACR_IDLE)
         main_d[`ACR_MC_START] = 1'b0;
      if (done_evt)
      begin
         if (!lock_q)
            res_d = core_result;
         main_d[`ACR_MC_DONE] = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Bus answer
   // ------------------------------------------------------------
   always_comb
   begin
      pready_d  = psel && penable && !pready;
      pslverr_d = 1'b0;
      prdata_d  = 32'h0000_0000;
      if (psel && penable && !pready)
      begin
         case (idx)
            10'(`ACR_IDX_RES_LOW):  prdata_d[7:0] = lo_view;
            10'(`ACR_IDX_RES_HIGH): prdata_d[7:0] = hi_view;
            10'(`ACR_IDX_MAIN_CTRL): prdata_d[7:0] = main_q;
            10'(`ACR_IDX_TRIG_CTRL): prdata_d[7:0] = trig_q;
            10'(`ACR_IDX_CHAN_SEL):  prdata_d[7:0] = chan_q;
            10'(`ACR_IDX_PIN_DIS):   prdata_d[7:0] = pin_q;
            default:                 pslverr_d = 1'b1;
         endcase
         if (pwrite)
            prdata_d = 32'h0000_0000;
      end
      irq_d = main_d[`ACR_MC_DONE] && main_d[`ACR_MC_IRQ_EN]
              && global_irq_en;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         main_q      <= `ACR_RESET_BYTE;
         trig_q      <= `ACR_RESET_BYTE;
         chan_q      <= `ACR_RESET_BYTE;
         pin_q       <= `ACR_RESET_BYTE;
         res_q       <= 10'h000;
         lock_q      <= 1'b0;
         act_q       <= '0;
         st_q        <= ACR_IDLE;
         cyc_q       <= 6'h00;
         first_q     <= 1'b1;
         trig_lvl_q  <= 1'b0;
         pready      <= 1'b0;
         prdata      <= 32'h0000_0000;
         pslverr     <= 1'b0;
         conv_irq    <= 1'b0;
         core_busy   <= 1'b0;
         core_sample <= 1'b0;
         core_sel    <= 6'h00;
         pin_buf_off <= 6'h00;
         pin_read    <= 6'h00;
      end
      else if (clk_en)
      begin
         main_q      <= main_d;
         trig_q      <= trig_d;
         chan_q      <= chan_d;
         pin_q       <= pin_d;
         res_q       <= res_d;
         lock_q      <= lock_d;
         act_q       <= act_d;
         st_q        <= st_d;
         cyc_q       <= cyc_d;
         first_q     <= first_d;
         trig_lvl_q  <= trig_lvl_d;
         pready      <= pready_d;
         prdata      <= prdata_d;
         pslverr     <= pslverr_d;
         conv_irq    <= irq_d;
         core_busy   <= (st_d == ACR_BUSY);
         core_sample <= sample_d;
         core_sel    <= {act_d.reference, act_d.channel};
         pin_buf_off <= pin_d[5:0];
         pin_read    <= pin_in & ~pin_d[5:0];
      end
   end

endmodule : acr_ctrl

//--- acr_ctrl_assertions.sv
module acr_ctrl_chk
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic [11:0] paddr,
   input  wire logic        pready,
   input  wire logic        pslverr,
   // Status
   input  wire logic        global_irq_en,
   input  wire logic        conv_irq,
   input  wire logic        core_busy,
   input  wire logic        core_sample,
   input  wire logic [5:0]  core_sel,
   input  wire logic [5:0]  pin_in,
   input  wire logic [5:0]  pin_buf_off,
   input  wire logic [5:0]  pin_read
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_apb_wait_state: assert property (psel && penable && !$past(penable)
      |-> !pready ##1 pready) else $error("pready not after one wait");
   a_apb_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_unmapped_err: assert property (pready |-> pslverr == !(paddr inside
      {12'h1E0, 12'h1E4, 12'h1E8, 12'h1EC, 12'h1F0, 12'h1F8}))
      else $error("pslverr does not match address map");
   a_irq_global: assert property (conv_irq |-> $past(global_irq_en))
      else $error("interrupt without global enable");
   a_done_pulse: assert property (core_sample |=> !core_sample)
      else $error("completion pulse too long");
   // Shortest conversion is 13 ticks of a divide-by-two clock
   a_busy_min: assert property ($rose(core_busy) |-> core_busy[*8])
      else $error("conversion ended too early");
   a_sel_hold: assert property (core_busy && $past(core_busy)
      |-> $stable(core_sel)) else $error("selection changed mid run");
   a_pin_gate: assert property ($past(presetn)
      |-> pin_read == ($past(pin_in) & ~pin_buf_off))
      else $error("pin read not gated");
   a_buf_by_write: assert property (!$stable(pin_buf_off)
      |-> pready || $past(pready)) else $error("disable bits moved alone");
endmodule : acr_ctrl_chk

bind acr_ctrl acr_ctrl_chk chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .global_irq_en(global_irq_en), .conv_irq(conv_irq),
   .core_busy(core_busy), .core_sample(core_sample), .core_sel(core_sel),
   .pin_in(pin_in), .pin_buf_off(pin_buf_off), .pin_read(pin_read));

//--- acr_ctrl_bench.sv
`include "acr_cfg.svh"

module acr_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [11:0] LO = {2'b0, `ACR_IDX_RES_LOW, 2'b0};
   localparam logic [11:0] HI = {2'b0, `ACR_IDX_RES_HIGH, 2'b0};
   localparam logic [11:0] MC = {2'b0, `ACR_IDX_MAIN_CTRL, 2'b0};
   localparam logic [11:0] TC = {2'b0, `ACR_IDX_TRIG_CTRL, 2'b0};
   localparam logic [11:0] CS = {2'b0, `ACR_IDX_CHAN_SEL, 2'b0};
   localparam logic [11:0] PD = {2'b0, `ACR_IDX_PIN_DIS, 2'b0};

   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, global_irq_en = 1'b0, irq_ack = 1'b0;
   logic        clk_en = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:1]  trig_src = 7'h00;
   logic [9:0]  core_result = 10'h000;
   logic [5:0]  pin_in = 6'h00, core_sel, pin_buf_off, pin_read;
   logic        pready, pslverr, conv_irq, core_busy, core_sample, er;
   int          err_count = 0, tests_run = 0, cyc = 0, n;

   acr_ctrl dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .global_irq_en(global_irq_en),
      .irq_ack(irq_ack), .conv_irq(conv_irq), .trig_src(trig_src),
      .core_result(core_result), .core_busy(core_busy),
      .core_sample(core_sample), .core_sel(core_sel), .pin_in(pin_in),
      .pin_buf_off(pin_buf_off), .pin_read(pin_read));

   always #2 pclk = ~pclk;

   // Generous ceiling: the whole run needs well under 10000 cycles
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_count++;
         conclude();
      end
   end

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wt(int lim);
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (core_sample !== 1'b1 && n < lim);
   endtask : wt

   // The prescaler restarts from zero at each start; the bounds still allow up to one tick of slack
   task automatic conv(logic [7:0] v, int t, int dv);
      apb(1'b1, MC, {24'h0, v});
      wt(4000);
      chk("conv length", 32'(n >= (t-1)*dv-2 && n <= t*dv+4), 1);
   endtask : conv

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      logic [11:0] regs [6] = '{LO, HI, MC, TC, CS, PD};
      foreach (regs[i])
      begin
         apb(1'b0, regs[i], 32'h0);
         chk("reset value", rd, 32'h0);
      end
      apb(1'b0, 12'h1F4, 32'h0);
      chk("unmapped error", 32'(er), 1);
      chk("unmapped data", rd, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_pins;
      pin_in <= 6'h3F;
      apb(1'b1, PD, 32'h15);
      repeat (2) @(posedge pclk);
      chk("buffer off", 32'(pin_buf_off), 32'h15);
      chk("pin read", 32'(pin_read), 32'h2A);
      apb(1'b0, PD, 32'h0);
      chk("disable readback", rd, 32'h15);
      $display("test pins done");
   endtask : t_pins

   task automatic t_conv;
      core_result <= 10'h2B5;
      conv(8'hC0, 25, 2);
      apb(1'b0, MC, 32'h0);
      chk("done set", rd, 32'h90);
      apb(1'b0, LO, 32'h0);
      chk("right low", rd, 32'hB5);
      apb(1'b0, HI, 32'h0);
      chk("right high", rd, 32'h02);
      apb(1'b1, CS, 32'h20);
      apb(1'b0, LO, 32'h0);
      chk("left low", rd, 32'h40);
      apb(1'b0, HI, 32'h0);
      chk("left high", rd, 32'hAD);
      apb(1'b1, MC, 32'h80);
      apb(1'b0, MC, 32'h0);
      chk("zero keeps flag", rd, 32'h90);
      apb(1'b1, MC, 32'h90);
      apb(1'b0, MC, 32'h0);
      chk("one clears flag", rd, 32'h80);
      $display("test conversion done");
   endtask : t_conv

   task automatic t_lock;
      apb(1'b1, CS, 32'h0);
      apb(1'b0, LO, 32'h0);
      core_result <= 10'h155;
      apb(1'b1, MC, 32'hD0);
      apb(1'b0, MC, 32'h0);
      chk("start reads one", rd, 32'hC0);
      wt(4000);
      apb(1'b0, LO, 32'h0);
      chk("locked low", rd, 32'hB5);
      apb(1'b0, HI, 32'h0);
      chk("locked high", rd, 32'h02);
      conv(8'hD0, 13, 2);
      apb(1'b0, LO, 32'h0);
      chk("new low", rd, 32'h55);
      apb(1'b0, HI, 32'h0);
      chk("new high", rd, 32'h01);
      $display("test lock done");
   endtask : t_lock

   // Selection latch, clock-enable freeze and abort by disable
   task automatic t_hold;
      apb(1'b1, CS, 32'h43);
      apb(1'b1, MC, 32'hD0);
      repeat (2) @(posedge pclk);
      chk("sel at start", 32'(core_sel), 32'h13);
      apb(1'b1, CS, 32'h82);
      repeat (2) @(posedge pclk);
      chk("sel held", 32'(core_sel), 32'h13);
      clk_en <= 1'b0;
      repeat (60) @(posedge pclk);
      chk("frozen busy", 32'(core_busy), 1);
      clk_en <= 1'b1;
      wt(4000);
      chk("thawed done", 32'(core_sample), 1);
      apb(1'b1, MC, 32'hD0);
      repeat (2) @(posedge pclk);
      chk("sel after done", 32'(core_sel), 32'h22);
      repeat (10) @(posedge pclk);
      apb(1'b1, MC, 32'h0);
      repeat (2) @(posedge pclk);
      chk("abort idle", 32'(core_busy), 0);
      apb(1'b0, MC, 32'h0);
      chk("abort control", rd, 32'h0);
      conv(8'hC0, 25, 2);
      $display("test hold done");
   endtask : t_hold

   task automatic t_prescale;
      int dv [8] = '{2, 2, 4, 8, 16, 32, 64, 128};
      for (int c = 0; c < 8; c++)
         conv(8'hD0 | 8'(c), 13, dv[c]);
      $display("test prescaler done");
   endtask : t_prescale

   task automatic t_irq;
      global_irq_en <= 1'b1;
      conv(8'hD8, 13, 2);
      repeat (3) @(posedge pclk);
      chk("irq raised", 32'(conv_irq), 1);
      global_irq_en <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("irq masked", 32'(conv_irq), 0);
      global_irq_en <= 1'b1;
      irq_ack <= 1'b1;
      @(posedge pclk);
      irq_ack <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("irq acked", 32'(conv_irq), 0);
      apb(1'b0, MC, 32'h0);
      chk("ack clears flag", rd, 32'h88);
      $display("test interrupt done");
   endtask : t_irq

   task automatic t_auto;
      apb(1'b1, TC, 32'h1);
      apb(1'b1, MC, 32'h90);
      trig_src <= 7'h01;
      repeat (8) @(posedge pclk);
      chk("no auto", 32'(core_busy), 0);
      trig_src <= 7'h00;
      apb(1'b1, MC, 32'hB0);
      for (int c = 1; c < 8; c++)
      begin
         apb(1'b1, TC, 32'(c));
         trig_src <= 7'h01 << (c - 1);
         wt(200);
         chk("auto start", 32'(core_sample), 1);
         trig_src <= 7'h00;
         apb(1'b1, MC, 32'hB0);
      end
      apb(1'b1, TC, 32'h1);
      trig_src <= 7'h02;
      apb(1'b1, TC, 32'h2);
      wt(200);
      chk("switch start", 32'(core_sample), 1);
      apb(1'b0, MC, 32'h0);
      chk("flag before switch", rd, 32'hB0);
      // Old source low, so only a forced level keeps this switch quiet
      trig_src <= 7'h00;
      apb(1'b1, TC, 32'h0);
      repeat (8) @(posedge pclk);
      chk("free run quiet", 32'(core_busy), 0);
      $display("test auto trigger done");
   endtask : t_auto

   task automatic conclude;
      $display("compares %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude

   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_pins();
      t_conv();
      t_lock();
      t_hold();
      t_prescale();
      t_irq();
      t_auto();
      conclude();
   end
endmodule : acr_ctrl_bench
